// ==== cpr_readout.sv ====
// Colour and proximity result registers with host byte access
`timescale 1ns/1ps
`include "cpr_map.svh"

module cpr_readout #(
    parameter logic [3:0] REV_MINOR = 4'ha // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire cpr_pkg::cpr_reg_req_t reg_req,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    input wire logic colour_done,
    input wire cpr_pkg::cpr_colour_t colour_sample,
    input wire logic ir_route_sel,
    input wire logic prox_done,
    input wire logic [9:0] prox_adc,
    input wire cpr_pkg::cpr_thresh_t prox_thresh,
    output logic [4:0] prox_pulses_q,
    output logic prox_below_q,
    output logic prox_above_q,
    output logic pulse_ctrl_en_q
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [15:0] chan_q [4];
    logic [15:0] chan_d [4];
    logic [7:0] prox_lo_q;
    logic [7:0] prox_lo_d;
    logic [7:0] prox_hi_q;
    logic [7:0] prox_hi_d;
    logic [7:0] prox_shadow_q;
    logic [7:0] prox_shadow_d;
    logic [7:0] cfg_b_q;
    logic [7:0] cfg_b_d;
    logic [7:0] pulse_cfg_q;
    logic [7:0] pulse_cfg_d;
    logic [7:0] reg_rdata_d;
    logic reg_rvalid_d;
    logic prox_below_d;
    logic prox_above_d;
    logic [4:0] prox_pulses_d;
    logic pulse_ctrl_en_d;
    logic [2:0] pulse_lg;
    logic [13:0] scaled;
    logic pulse_ctrl_on;

    // Pulse control runs unless the disable bit is set
    assign pulse_ctrl_on = ~pulse_cfg_q[`CPR_PCTL_DIS_BIT];

    cpr_prox_pulse u_pulse (
        .clk(clk),
        .rst(rst),
        .prox_done(prox_done),
        .prox_adc(prox_adc),
        .pulse_ctrl_en(pulse_ctrl_on),
        .pulse_lg_q(pulse_lg),
        .scaled(scaled)
    );

    // Channel word of a colour byte address: clear, red, green (or IR when ir_route_sel is set), blue
    function automatic logic [1:0] chan_of(input logic [7:0] addr);
        logic [7:0] off;
        off = addr - `CPR_ADDR_CLEAR_LOW;
        chan_of = off[2:1];
    endfunction

    function automatic logic is_colour(input logic [7:0] addr);
        is_colour = (addr >= `CPR_ADDR_CLEAR_LOW) &&
                    (addr <= `CPR_ADDR_BLUE_HIGH);
    endfunction

    // ****************************************************************
    // Result capture
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            chan_d[i] = chan_q[i];
        end
        prox_lo_d = prox_lo_q;
        prox_hi_d = prox_hi_q;
        prox_below_d = prox_below_q;
        prox_above_d = prox_above_q;
        if (colour_done) begin
            chan_d[0] = colour_sample.clear;
            chan_d[1] = colour_sample.red;
            chan_d[2] = ir_route_sel ? colour_sample.ir
                                     : colour_sample.green;
            chan_d[3] = colour_sample.blue;
        end
        if (prox_done) begin
            if (pulse_ctrl_on) begin
                prox_lo_d = scaled[7:0];
                prox_hi_d = {2'h0, scaled[13:8]};
                prox_below_d = scaled < prox_thresh.low[13:0];
                prox_above_d = scaled > prox_thresh.high[13:0];
            end else begin
                prox_lo_d = prox_adc[9:2];
                prox_hi_d = {6'h00, prox_adc[1:0]};
                prox_below_d = prox_adc[9:2] < prox_thresh.low[7:0];
                prox_above_d = prox_adc[9:2] > prox_thresh.high[7:0];
            end
        end
    end

    // ****************************************************************
    // Pulse count and mode outputs
    // ****************************************************************
    always_comb begin
        prox_pulses_d = 5'(5'h01 << pulse_lg);
        pulse_ctrl_en_d = pulse_ctrl_on;
    end

    // ****************************************************************
    // Host register access
    // ****************************************************************
    always_comb begin
        reg_rdata_d = reg_rdata_q;
        reg_rvalid_d = 1'b0;
        prox_shadow_d = prox_shadow_q;
        cfg_b_d = cfg_b_q;
        pulse_cfg_d = pulse_cfg_q;
        if (reg_req.rd) begin
            reg_rvalid_d = 1'b1;
            case (reg_req.addr)
                `CPR_ADDR_PROX_LOW: begin
                    reg_rdata_d = prox_lo_q;
                    prox_shadow_d = prox_hi_q;
                end
                `CPR_ADDR_PROX_HIGH: begin
                    reg_rdata_d = prox_shadow_q;
                end
                `CPR_ADDR_REV_MINOR: begin
                    reg_rdata_d = {4'h0, REV_MINOR} & `CPR_REV_MINOR_MASK;
                end
                `CPR_ADDR_CFG_B: begin
                    reg_rdata_d = cfg_b_q;
                end
                `CPR_ADDR_PULSE_CFG: begin
                    reg_rdata_d = pulse_cfg_q;
                end
                default: begin
                    if (is_colour(reg_req.addr)) begin
                        reg_rdata_d = reg_req.addr[0]
                            ? chan_q[chan_of(reg_req.addr)][15:8]
                            : chan_q[chan_of(reg_req.addr)][7:0];
                    end else begin
                        reg_rdata_d = `CPR_UNMAPPED_READ;
                    end
                end
            endcase
        end
        if (reg_req.wr) begin
            case (reg_req.addr)
                `CPR_ADDR_CFG_B: begin
                    cfg_b_d = reg_req.wdata;
                end
                `CPR_ADDR_PULSE_CFG: begin
                    pulse_cfg_d = reg_req.wdata;
                end
                default: begin
                    cfg_b_d = cfg_b_q;
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                chan_q[i] <= `CPR_RESULT_RESET;
            end
            prox_lo_q <= `CPR_BYTE_RESET;
            prox_hi_q <= `CPR_BYTE_RESET;
            prox_shadow_q <= `CPR_BYTE_RESET;
            cfg_b_q <= `CPR_CFG_B_RESET;
            pulse_cfg_q <= `CPR_PULSE_CFG_RESET;
            reg_rdata_q <= `CPR_BYTE_RESET;
            reg_rvalid_q <= 1'b0;
            prox_below_q <= 1'b0;
            prox_above_q <= 1'b0;
            prox_pulses_q <= `CPR_PULSES_RESET;
            pulse_ctrl_en_q <= 1'b1;
        end else begin
            for (int i = 0; i < 4; i++) begin
                chan_q[i] <= chan_d[i];
            end
            prox_lo_q <= prox_lo_d;
            prox_hi_q <= prox_hi_d;
            prox_shadow_q <= prox_shadow_d;
            cfg_b_q <= cfg_b_d;
            pulse_cfg_q <= pulse_cfg_d;
            reg_rdata_q <= reg_rdata_d;
            reg_rvalid_q <= reg_rvalid_d;
            prox_below_q <= prox_below_d;
            prox_above_q <= prox_above_d;
            prox_pulses_q <= prox_pulses_d;
            pulse_ctrl_en_q <= pulse_ctrl_en_d;
        end
    end

endmodule // cpr_readout

// ==== cpr_map.svh ====
// Register offsets, reset values and pulse control steps of the result readout
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CPR_ADDR_CLEAR_LOW 8'h94
`define CPR_ADDR_CLEAR_HIGH 8'h95
`define CPR_ADDR_RED_LOW 8'h96
`define CPR_ADDR_RED_HIGH 8'h97
`define CPR_ADDR_GREEN_LOW 8'h98
`define CPR_ADDR_GREEN_HIGH 8'h99
`define CPR_ADDR_BLUE_LOW 8'h9a
`define CPR_ADDR_BLUE_HIGH 8'h9b
`define CPR_ADDR_PROX_LOW 8'h9c
`define CPR_ADDR_PROX_HIGH 8'h9d
`define CPR_ADDR_REV_MINOR 8'h9e
`define CPR_ADDR_CFG_B 8'h9f
`define CPR_ADDR_PULSE_CFG 8'hae

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CPR_PCTL_DIS_BIT 6
`define CPR_RESULT_RESET 16'h0000
`define CPR_BYTE_RESET 8'h00
`define CPR_CFG_B_RESET 8'h00
`define CPR_PULSE_CFG_RESET 8'h3f
`define CPR_PULSES_RESET 5'h10
`define CPR_REV_MINOR_MASK 8'h0f
`define CPR_UNMAPPED_READ 8'h00

// ****************************************************************
// Pulse control: log2 of pulse count and magnitude steps
// ****************************************************************
`define CPR_LG_MAX 3'h4
`define CPR_PCTL_STEP_1 10'h300
`define CPR_PCTL_STEP_2 10'h200
`define CPR_PCTL_STEP_4 10'h100
`define CPR_PCTL_STEP_8 10'h080

`endif

// ==== cpr_pkg.sv ====
// Types shared by the result readout modules
package cpr_pkg;

    // ****************************************************************
    // Register access request from the serial host interface
    // ****************************************************************
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cpr_reg_req_t;

    // ****************************************************************
    // One completed colour measurement
    // ****************************************************************
    typedef struct packed {
        logic [15:0] clear;
        logic [15:0] red;
        logic [15:0] green;
        logic [15:0] ir;
        logic [15:0] blue;
    } cpr_colour_t;

    // ****************************************************************
    // Proximity threshold pair
    // ****************************************************************
    typedef struct packed {
        logic [15:0] low;
        logic [15:0] high;
    } cpr_thresh_t;

endpackage

// ==== cpr_prox_apc.sv ====
// Automatic pulse control: pulse count choice and result scaling
`timescale 1ns/1ps
`include "cpr_map.svh"

module cpr_prox_pulse (
    input wire logic clk,
    input wire logic rst,
    input wire logic prox_done,
    input wire logic [9:0] prox_adc,
    input wire logic pulse_ctrl_en,
    output logic [2:0] pulse_lg_q,
    output logic [13:0] scaled
);

    logic [2:0] pulse_lg_d;

    // Fewer pulses for a stronger reflection
    function automatic logic [2:0] pick_lg(input logic [9:0] mag);
        if (mag >= `CPR_PCTL_STEP_1) begin
            pick_lg = 3'h0;
        end else if (mag >= `CPR_PCTL_STEP_2) begin
            pick_lg = 3'h1;
        end else if (mag >= `CPR_PCTL_STEP_4) begin
            pick_lg = 3'h2;
        end else if (mag >= `CPR_PCTL_STEP_8) begin
            pick_lg = 3'h3;
        end else begin
            pick_lg = `CPR_LG_MAX;
        end
    endfunction

    // ****************************************************************
    // Scaling by sixteen over the pulses emitted for this sample
    // ****************************************************************
    always_comb begin
        scaled = 14'({4'h0, prox_adc} << (`CPR_LG_MAX - pulse_lg_q));
        pulse_lg_d = pulse_lg_q;
        if (prox_done) begin
            if (pulse_ctrl_en) begin
                pulse_lg_d = pick_lg(prox_adc);
            end else begin
                pulse_lg_d = `CPR_LG_MAX;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_lg_q <= `CPR_LG_MAX;
        end else begin
            pulse_lg_q <= pulse_lg_d;
        end
    end

endmodule // cpr_prox_pulse

// ==== cpr_readout_properties.sv ====
// Port-level checks on the result readout
`timescale 1ns/1ps
module cpr_readout_properties (
    input wire logic clk,
    input wire logic rst,
    input wire cpr_pkg::cpr_reg_req_t reg_req,
    input wire logic reg_rvalid_q,
    input wire logic prox_done,
    input wire logic [9:0] prox_adc,
    input wire cpr_pkg::cpr_thresh_t prox_thresh,
    input wire logic [4:0] prox_pulses_q,
    input wire logic prox_below_q,
    input wire logic prox_above_q,
    input wire logic pulse_ctrl_en_q
);
    // ****
    // Checks
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] top8;
    logic [7:0] lo8;
    logic [7:0] hi8;
    assign top8 = prox_adc[9:2];
    assign lo8 = prox_thresh.low[7:0];
    assign hi8 = prox_thresh.high[7:0];
    property p_rv; reg_req.rd |=> reg_rvalid_q; endproperty
    a_rv: assert property (p_rv) else $error("read unanswered");
    property p_dis; reg_req.wr && reg_req.addr == 8'hae
        && reg_req.wdata[6] |=> ##[0:1] !pulse_ctrl_en_q; endproperty
    a_dis: assert property (p_dis) else $error("pulse ctrl on");
    property p_set; $onehot(prox_pulses_q); endproperty
    a_set: assert property (p_set) else $error("bad pulses");
    property p_few; prox_done && pulse_ctrl_en_q && prox_adc >= 10'h300
        |-> ##2 prox_pulses_q == 5'h01; endproperty
    a_few: assert property (p_few) else $error("strong not 1");
    property p_many; prox_done && pulse_ctrl_en_q && prox_adc < 10'h080
        |-> ##2 prox_pulses_q == 5'h10; endproperty
    a_many: assert property (p_many) else $error("weak not 16");
    property p_off; prox_done && !pulse_ctrl_en_q
        |-> ##2 prox_pulses_q == 5'h10; endproperty
    a_off: assert property (p_off) else $error("off not 16");
    property p_lo; prox_done && !pulse_ctrl_en_q
        |=> prox_below_q == ($past(top8) < $past(lo8)); endproperty
    a_lo: assert property (p_lo) else $error("below wrong");
    property p_hi; prox_done && !pulse_ctrl_en_q
        |=> prox_above_q == ($past(top8) > $past(hi8)); endproperty
    a_hi: assert property (p_hi) else $error("above wrong");
    c_rd: cover property (reg_req.rd && reg_req.addr == 8'h9c);
    c_off: cover property (prox_done && !pulse_ctrl_en_q);
    c_few: cover property (prox_done && prox_adc >= 10'h300);
endmodule // cpr_readout_properties

bind cpr_readout cpr_readout_properties i_cpr_readout_properties (
    .clk, .rst, .reg_req, .reg_rvalid_q, .prox_done, .prox_adc,
    .prox_thresh, .prox_pulses_q, .prox_below_q, .prox_above_q,
    .pulse_ctrl_en_q
);

// ==== cpr_host_model.sv ====
// Host model issuing register reads and writes
`timescale 1ns/1ps
module cpr_host_model (
    input wire logic clk,
    output cpr_pkg::cpr_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata_q,
    input wire logic reg_rvalid_q
);
    // ****
    // Bus tasks
    // ****
    initial reg_req = '0;
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 reg_req.rd = 1'h1;
        reg_req.addr = a;
        @(posedge clk);
        #1 reg_req.rd = 1'h0;
        reg_req.addr = ~a;
        d = reg_rvalid_q ? reg_rdata_q : 8'hxx;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_req.wr = 1'h1;
        reg_req.addr = a;
        reg_req.wdata = (a == 8'h9f) ? 8'h00 : d;
        @(posedge clk);
        #1 reg_req.wr = 1'h0;
        reg_req.wdata = ~reg_req.wdata;
    endtask
endmodule // cpr_host_model

// ==== cpr_readout_test.sv ====
// Self-checking bench for the result readout
`timescale 1ns/1ps
module cpr_readout_test;
    logic clk = 1'h0;
    logic rst = 1'h1;
    cpr_pkg::cpr_reg_req_t reg_req;
    logic [7:0] reg_rdata_q;
    logic reg_rvalid_q;
    logic colour_done = 1'h0;
    cpr_pkg::cpr_colour_t colour_sample = '0;
    logic ir_route_sel = 1'h0;
    logic prox_done = 1'h0;
    logic [9:0] prox_adc = 10'h000;
    cpr_pkg::cpr_thresh_t prox_thresh = '0;
    logic [4:0] prox_pulses_q;
    logic prox_below_q;
    logic prox_above_q;
    logic pulse_ctrl_en_q;
    logic [7:0] d;
    int fail_count = 0;
    int checked = 0;
    always #12.5 clk = ~clk;
    cpr_readout i_cpr_readout (.clk, .rst, .reg_req, .reg_rdata_q,
        .reg_rvalid_q, .colour_done, .colour_sample, .ir_route_sel,
        .prox_done, .prox_adc, .prox_thresh, .prox_pulses_q,
        .prox_below_q, .prox_above_q, .pulse_ctrl_en_q);
    cpr_host_model i_cpr_host_model (.clk, .reg_req, .reg_rdata_q,
        .reg_rvalid_q);
    // ****
    // Helpers
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        i_cpr_host_model.rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask
    task automatic cdone(input cpr_pkg::cpr_colour_t s);
        @(posedge clk);
        #1 colour_done = 1'h1;
        colour_sample = s;
        @(posedge clk);
        #1 colour_done = 1'h0;
        colour_sample = ~s;
    endtask
    task automatic pdone(input logic [9:0] a);
        @(posedge clk);
        #1 prox_done = 1'h1;
        prox_adc = a;
        @(posedge clk);
        #1 prox_done = 1'h0;
        prox_adc = ~a;
        @(posedge clk);
        #1;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        for (int a = 8'h94; a <= 8'h9d; a++) begin
            rdchk(8'(a), 8'h00);
        end
        i_cpr_host_model.wr(8'h94, 8'h5a);
        rdchk(8'h94, 8'h00);
        rdchk(8'ha5, 8'h00);
        rdchk(8'h9f, 8'h00);
    endtask
    task automatic t_colour;
        cpr_pkg::cpr_colour_t s;
        s = {16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h0fed};
        cdone(s);
        rdchk(8'h94, 8'h34);
        rdchk(8'h95, 8'h12);
        rdchk(8'h96, 8'h78);
        rdchk(8'h97, 8'h56);
        rdchk(8'h98, 8'hbc);
        rdchk(8'h99, 8'h9a);
        rdchk(8'h9a, 8'hed);
        rdchk(8'h9b, 8'h0f);
        ir_route_sel = 1'h1;
        cdone(~s);
        cdone(s);
        rdchk(8'h98, 8'hf0);
        rdchk(8'h99, 8'hde);
    endtask
    task automatic t_apc;
        pdone(10'h3ff);
        chk({11'h000, prox_pulses_q}, 16'h0001);
        rdchk(8'h9c, 8'hff);
        rdchk(8'h9d, 8'h03);
        pdone(10'h123);
        chk({11'h000, prox_pulses_q}, 16'h0004);
        rdchk(8'h9c, 8'h30);
        pdone(10'h050);
        rdchk(8'h9d, 8'h12);
        chk({11'h000, prox_pulses_q}, 16'h0010);
        rdchk(8'h9c, 8'h40);
        rdchk(8'h9d, 8'h01);
    endtask
    task automatic t_off;
        i_cpr_host_model.wr(8'hae, 8'h7f);
        @(posedge clk);
        #1 chk({15'h0000, pulse_ctrl_en_q}, 16'h0000);
        rdchk(8'hae, 8'h7f);
        prox_thresh = {16'h00b4, 16'h00c0};
        pdone(10'h2cd);
        chk({11'h000, prox_pulses_q}, 16'h0010);
        chk({14'h0000, prox_below_q, prox_above_q}, 16'h0002);
        rdchk(8'h9c, 8'hb3);
        rdchk(8'h9d, 8'h01);
    endtask
    task automatic summarize;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 1'h0;
        t_reset;
        t_colour;
        t_apc;
        t_off;
        summarize;
    end
    initial begin
        #50000;
        fail_count++;
        summarize;
    end
endmodule // cpr_readout_test
